// ---- verilog/hvp_port_map.svh ----
// offsets, field positions, reset values and pin masks of the port block
// assumes an 8-bit register address and 8-bit data on the register port
//
// Functional notes
// - 45 programmable pins in six two-way ports, one direction bit per pin.
// - direction bit 0 makes the pin an input with its driver off.
// - direction bit 1 drives the pin from its output latch bit; open-drain p5 drives only 0s, p8 only 1s.
// - reading an output bit returns the latch, not the pin.
// - writes always reach the latch; an input pin stays undriven.
// - four high-voltage high-side open-drain ports; three output-only.
// - reset switches every high-voltage high-side driver off.
// - control bit 0 set at 0x38 selects slowed high-voltage transitions.
// - reset clears control bit 0, selecting strong drive.
// - reset clears all two-way port direction bits: pins start as inputs.
`ifndef HVP_PORT_MAP_SVH
`define HVP_PORT_MAP_SVH

// *****************************************************************
// register offsets
// *****************************************************************
`define HVP_OFS_P0_DATA  8'h00
`define HVP_OFS_P1_DATA  8'h02
`define HVP_OFS_P2_DATA  8'h04
`define HVP_OFS_P2_DIR   8'h05
`define HVP_OFS_P3_DATA  8'h06
`define HVP_OFS_P4_DATA  8'h08
`define HVP_OFS_P4_DIR   8'h09
`define HVP_OFS_P5_DATA  8'h0A
`define HVP_OFS_P5_DIR   8'h0B
`define HVP_OFS_P6_DATA  8'h0C
`define HVP_OFS_P6_DIR   8'h0D
`define HVP_OFS_P7_DATA  8'h0E
`define HVP_OFS_P7_DIR   8'h0F
`define HVP_OFS_P8_DATA  8'h10
`define HVP_OFS_P8_DIR   8'h11
`define HVP_OFS_HV_CTRL  8'h38

// *****************************************************************
// fields, reset values, implemented pins
// *****************************************************************
`define HVP_HV_CTRL_SLOW_BIT 0
`define HVP_RST_LATCH        8'h00
`define HVP_RST_DIR          8'h00
`define HVP_RST_HV_CTRL      8'h00
`define HVP_RD_UNMAPPED      8'h00
`define HVP_MASK_FULL        8'hFF
`define HVP_MASK_P4          8'hFE
`define HVP_MASK_P6          8'h3F

`endif

// ---- verilog/hvp_pkg.sv ----
// types shared by the port block files
// assumes the constants of hvp_port_map.svh for values
`default_nettype none
package hvp_pkg;

	// register port request, one cycle per access
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} hvp_bus_t;

	// one 8-bit pad group: level driven and active-low enable
	typedef struct packed {
		logic [7:0] lvl;
		logic [7:0] oe_n;
	} hvp_pad_t;

endpackage
`default_nettype wire

// ---- verilog/hvp_gpio_port.sv ----
// direction and output latch of one two-way port, with its read value
// assumes pins already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "hvp_port_map.svh"
module hvp_gpio_port #(
	parameter logic [7:0] MASK = 8'hFF
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       wr_data,
	input  wire logic       wr_dir,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] pin,
	output logic      [7:0] latch_reg,
	output logic      [7:0] dir_reg,
	output logic      [7:0] rd_val
);
	import hvp_pkg::*;

	// latch is written whatever the direction
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latch_reg <= `HVP_RST_LATCH;
		end else if (wr_data) begin
			latch_reg <= wdata & MASK;
		end
	end

	// missing pins keep direction 0 so they never drive
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dir_reg <= `HVP_RST_DIR;
		end else if (wr_dir) begin
			dir_reg <= wdata & MASK;
		end
	end

	assign rd_val = ((dir_reg & latch_reg) | (~dir_reg & pin)) & MASK;

endmodule // hvp_gpio_port
`default_nettype wire

// ---- verilog/hvp_hv_out.sv ----
// output latch of one output-only high-voltage port
// assumes an external pull-down to the pull-down rail on every pin
`timescale 1ns/10ps
`default_nettype none
`include "hvp_port_map.svh"
module hvp_hv_out (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] latch_reg
);
	import hvp_pkg::*;

	// reset leaves the high-side driver off, pull-down sets the level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latch_reg <= `HVP_RST_LATCH;
		end else if (wr) begin
			latch_reg <= wdata;
		end
	end

endmodule // hvp_hv_out
`default_nettype wire

// ---- verilog/hvp_port_top.sv ----
// parallel port block: direction, latches, reads, high-voltage drive
// assumes a one-cycle strobe register port and pins synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "hvp_port_map.svh"
module hvp_port_top (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire hvp_pkg::hvp_bus_t bus,
	output logic           [7:0]  rdata,
	input  wire logic      [7:0]  p2_pin,
	input  wire logic      [7:0]  p4_pin,
	input  wire logic      [7:0]  p5_pin,
	input  wire logic      [7:0]  p6_pin,
	input  wire logic      [7:0]  p7_pin,
	input  wire logic      [7:0]  p8_pin,
	output hvp_pkg::hvp_pad_t     p0_pad,
	output hvp_pkg::hvp_pad_t     p1_pad,
	output hvp_pkg::hvp_pad_t     p2_pad,
	output hvp_pkg::hvp_pad_t     p3_pad,
	output hvp_pkg::hvp_pad_t     p4_pad,
	output hvp_pkg::hvp_pad_t     p5_pad,
	output hvp_pkg::hvp_pad_t     p6_pad,
	output hvp_pkg::hvp_pad_t     p7_pad,
	output hvp_pkg::hvp_pad_t     p8_pad,
	output logic                  hv_slow
);
	import hvp_pkg::*;

	// *****************************************************************
	// pad helpers
	// *****************************************************************

	// push-pull pin: drives the latch while set to output
	function automatic hvp_pad_t cmos_pad(input logic [7:0] latch,
			input logic [7:0] dir);
		hvp_pad_t p;
		p.lvl  = latch;
		p.oe_n = ~dir;
		return p;
	endfunction

	// high-side open drain: only a 1 is ever driven
	function automatic hvp_pad_t hv_pad(input logic [7:0] on);
		hvp_pad_t p;
		p.lvl  = on;
		p.oe_n = ~on;
		return p;
	endfunction

	// low-side open drain: only a 0 is ever driven
	function automatic hvp_pad_t low_pad(input logic [7:0] latch,
			input logic [7:0] dir);
		hvp_pad_t p;
		p.lvl  = 8'h00;
		p.oe_n = ~(dir & ~latch);
		return p;
	endfunction

	// *****************************************************************
	// write decode
	// *****************************************************************
	logic wr_p0;
	logic wr_p1;
	logic wr_p2;
	logic wr_p2_dir;
	logic wr_p3;
	logic wr_p4;
	logic wr_p4_dir;
	logic wr_p5;
	logic wr_p5_dir;
	logic wr_p6;
	logic wr_p6_dir;
	logic wr_p7;
	logic wr_p7_dir;
	logic wr_p8;
	logic wr_p8_dir;
	logic wr_ctrl;

	assign wr_p0     = bus.wr && (bus.addr == `HVP_OFS_P0_DATA);
	assign wr_p1     = bus.wr && (bus.addr == `HVP_OFS_P1_DATA);
	assign wr_p2     = bus.wr && (bus.addr == `HVP_OFS_P2_DATA);
	assign wr_p2_dir = bus.wr && (bus.addr == `HVP_OFS_P2_DIR);
	assign wr_p3     = bus.wr && (bus.addr == `HVP_OFS_P3_DATA);
	assign wr_p4     = bus.wr && (bus.addr == `HVP_OFS_P4_DATA);
	assign wr_p4_dir = bus.wr && (bus.addr == `HVP_OFS_P4_DIR);
	assign wr_p5     = bus.wr && (bus.addr == `HVP_OFS_P5_DATA);
	assign wr_p5_dir = bus.wr && (bus.addr == `HVP_OFS_P5_DIR);
	assign wr_p6     = bus.wr && (bus.addr == `HVP_OFS_P6_DATA);
	assign wr_p6_dir = bus.wr && (bus.addr == `HVP_OFS_P6_DIR);
	assign wr_p7     = bus.wr && (bus.addr == `HVP_OFS_P7_DATA);
	assign wr_p7_dir = bus.wr && (bus.addr == `HVP_OFS_P7_DIR);
	assign wr_p8     = bus.wr && (bus.addr == `HVP_OFS_P8_DATA);
	assign wr_p8_dir = bus.wr && (bus.addr == `HVP_OFS_P8_DIR);
	assign wr_ctrl   = bus.wr && (bus.addr == `HVP_OFS_HV_CTRL);

	// *****************************************************************
	// output-only high-voltage ports
	// *****************************************************************
	logic [7:0] p0_latch;
	logic [7:0] p1_latch;
	logic [7:0] p3_latch;

	hvp_hv_out u_p0 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr        (wr_p0),
		.wdata     (bus.wdata),
		.latch_reg (p0_latch)
	);

	hvp_hv_out u_p1 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr        (wr_p1),
		.wdata     (bus.wdata),
		.latch_reg (p1_latch)
	);

	hvp_hv_out u_p3 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr        (wr_p3),
		.wdata     (bus.wdata),
		.latch_reg (p3_latch)
	);

	// *****************************************************************
	// two-way ports: 8 + 7 + 8 + 6 + 8 + 8 = 45 pins
	// *****************************************************************
	logic [7:0] p2_latch;
	logic [7:0] p2_dir;
	logic [7:0] p2_rd;
	logic [7:0] p4_latch;
	logic [7:0] p4_dir;
	logic [7:0] p4_rd;
	logic [7:0] p5_latch;
	logic [7:0] p5_dir;
	logic [7:0] p5_rd;
	logic [7:0] p6_latch;
	logic [7:0] p6_dir;
	logic [7:0] p6_rd;
	logic [7:0] p7_latch;
	logic [7:0] p7_dir;
	logic [7:0] p7_rd;
	logic [7:0] p8_latch;
	logic [7:0] p8_dir;
	logic [7:0] p8_rd;

	hvp_gpio_port #(.MASK(`HVP_MASK_FULL)) u_p2 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_data   (wr_p2),
		.wr_dir    (wr_p2_dir),
		.wdata     (bus.wdata),
		.pin       (p2_pin),
		.latch_reg (p2_latch),
		.dir_reg   (p2_dir),
		.rd_val    (p2_rd)
	);

	// bit 0 is an input-only pin, so it has no direction bit
	hvp_gpio_port #(.MASK(`HVP_MASK_P4)) u_p4 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_data   (wr_p4),
		.wr_dir    (wr_p4_dir),
		.wdata     (bus.wdata),
		.pin       (p4_pin),
		.latch_reg (p4_latch),
		.dir_reg   (p4_dir),
		.rd_val    ()
	);

	assign p4_rd = p4_rd_fix(p4_latch, p4_dir, p4_pin);

	// input-only bit 0 still reads its pin
	function automatic logic [7:0] p4_rd_fix(input logic [7:0] latch,
			input logic [7:0] dir, input logic [7:0] pin);
		logic [7:0] v;
		v = ((dir & latch) | (~dir & pin)) & `HVP_MASK_P4;
		v[0] = pin[0];
		return v;
	endfunction

	hvp_gpio_port #(.MASK(`HVP_MASK_FULL)) u_p5 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_data   (wr_p5),
		.wr_dir    (wr_p5_dir),
		.wdata     (bus.wdata),
		.pin       (p5_pin),
		.latch_reg (p5_latch),
		.dir_reg   (p5_dir),
		.rd_val    (p5_rd)
	);

	hvp_gpio_port #(.MASK(`HVP_MASK_P6)) u_p6 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_data   (wr_p6),
		.wr_dir    (wr_p6_dir),
		.wdata     (bus.wdata),
		.pin       (p6_pin),
		.latch_reg (p6_latch),
		.dir_reg   (p6_dir),
		.rd_val    (p6_rd)
	);

	hvp_gpio_port #(.MASK(`HVP_MASK_FULL)) u_p7 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_data   (wr_p7),
		.wr_dir    (wr_p7_dir),
		.wdata     (bus.wdata),
		.pin       (p7_pin),
		.latch_reg (p7_latch),
		.dir_reg   (p7_dir),
		.rd_val    (p7_rd)
	);

	// high-voltage two-way port, no internal pull-downs
	hvp_gpio_port #(.MASK(`HVP_MASK_FULL)) u_p8 (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_data   (wr_p8),
		.wr_dir    (wr_p8_dir),
		.wdata     (bus.wdata),
		.pin       (p8_pin),
		.latch_reg (p8_latch),
		.dir_reg   (p8_dir),
		.rd_val    (p8_rd)
	);

	// *****************************************************************
	// high-voltage drive control
	// *****************************************************************
	// a literal cannot be bit-selected, so the reset word gets a name
	localparam logic [7:0] HV_CTRL_RST = `HVP_RST_HV_CTRL;
	logic hv_ctrl_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hv_ctrl_reg <= HV_CTRL_RST[`HVP_HV_CTRL_SLOW_BIT];
		end else if (wr_ctrl) begin
			hv_ctrl_reg <= bus.wdata[`HVP_HV_CTRL_SLOW_BIT];
		end
	end

	assign hv_slow = hv_ctrl_reg;

	// *****************************************************************
	// pads
	// *****************************************************************
	// output-only ports read back their latch, driver follows it
	assign p0_pad = hv_pad(p0_latch);
	assign p1_pad = hv_pad(p1_latch);
	assign p3_pad = hv_pad(p3_latch);
	// p8 drives only when set to output and the latch holds 1
	assign p8_pad = hv_pad(p8_dir & p8_latch);
	assign p2_pad = cmos_pad(p2_latch, p2_dir);
	assign p4_pad = cmos_pad(p4_latch, p4_dir);
	assign p5_pad = low_pad(p5_latch, p5_dir);
	assign p6_pad = cmos_pad(p6_latch, p6_dir);
	assign p7_pad = cmos_pad(p7_latch, p7_dir);

	// *****************************************************************
	// read path: data valid the cycle after the strobe
	// *****************************************************************
	logic [7:0] rdata_next;

	always_comb begin
		unique case (bus.addr)
			`HVP_OFS_P0_DATA: rdata_next = p0_latch;
			`HVP_OFS_P1_DATA: rdata_next = p1_latch;
			`HVP_OFS_P2_DATA: rdata_next = p2_rd;
			`HVP_OFS_P2_DIR:  rdata_next = p2_dir;
			`HVP_OFS_P3_DATA: rdata_next = p3_latch;
			`HVP_OFS_P4_DATA: rdata_next = p4_rd;
			`HVP_OFS_P4_DIR:  rdata_next = p4_dir;
			`HVP_OFS_P5_DATA: rdata_next = p5_rd;
			`HVP_OFS_P5_DIR:  rdata_next = p5_dir;
			`HVP_OFS_P6_DATA: rdata_next = p6_rd;
			`HVP_OFS_P6_DIR:  rdata_next = p6_dir;
			`HVP_OFS_P7_DATA: rdata_next = p7_rd;
			`HVP_OFS_P7_DIR:  rdata_next = p7_dir;
			`HVP_OFS_P8_DATA: rdata_next = p8_rd;
			`HVP_OFS_P8_DIR:  rdata_next = p8_dir;
			`HVP_OFS_HV_CTRL: rdata_next = {7'h00, hv_ctrl_reg};
			default:          rdata_next = `HVP_RD_UNMAPPED;
		endcase
	end

	// zero outside a read answer keeps a stale value off the bus
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			rdata <= rdata_next;
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule // hvp_port_top
`default_nettype wire

// ---- testbench/hvp_port_props.sv ----
// concurrent checks on the port block's top-level ports
// assumes one clock and the register offsets of hvp_port_map.svh
`timescale 1ns/10ps
`default_nettype none
`include "hvp_port_map.svh"
module hvp_port_props (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire hvp_pkg::hvp_bus_t bus,
	input wire logic [7:0]        rdata,
	input wire logic [7:0]        p2_pin,
	input wire hvp_pkg::hvp_pad_t p0_pad,
	input wire hvp_pkg::hvp_pad_t p1_pad,
	input wire hvp_pkg::hvp_pad_t p2_pad,
	input wire hvp_pkg::hvp_pad_t p3_pad,
	input wire hvp_pkg::hvp_pad_t p4_pad,
	input wire hvp_pkg::hvp_pad_t p7_pad,
	input wire hvp_pkg::hvp_pad_t p8_pad,
	input wire logic              hv_slow
);
	import hvp_pkg::*;
	// ****************
	// properties
	// ****************
	default clocking @(posedge clk); endclocking

	a_rd_latency: assert property (disable iff (!rst_n)
		bus.rd && bus.addr == `HVP_OFS_P2_DATA |=> rdata ==
		$past((p2_pad.lvl & ~p2_pad.oe_n) | (p2_pin & p2_pad.oe_n)))
		else $error("port two read value wrong");
	a_rd_idle: assert property (disable iff (!rst_n)
		!bus.rd |=> rdata == 8'h00) else $error("read data not idle");
	a_dir_write: assert property (disable iff (!rst_n)
		bus.wr && bus.addr == `HVP_OFS_P2_DIR
		|=> p2_pad.oe_n == ~$past(bus.wdata))
		else $error("direction write not applied");
	a_latch_write: assert property (disable iff (!rst_n)
		bus.wr && bus.addr == `HVP_OFS_P7_DATA
		|=> p7_pad.lvl == $past(bus.wdata)) else $error("latch not written");
	a_missing_pin: assert property (disable iff (!rst_n)
		p4_pad.oe_n[0] && !p4_pad.lvl[0]) else $error("input-only pin driven");
	a_hv_write: assert property (disable iff (!rst_n)
		bus.wr && bus.addr == `HVP_OFS_P0_DATA
		|=> p0_pad.lvl == $past(bus.wdata))
		else $error("port zero latch not on its drivers");
	a_hv_drive: assert property (disable iff (!rst_n)
		p0_pad.oe_n == ~p0_pad.lvl && p1_pad.oe_n == ~p1_pad.lvl
		&& p3_pad.oe_n == ~p3_pad.lvl) else $error("high side drive wrong");
	a_p8_high: assert property (disable iff (!rst_n)
		p8_pad.oe_n == ~p8_pad.lvl) else $error("port eight drive wrong");
	a_hv_reset: assert property (
		!rst_n |=> &{p0_pad.oe_n, p1_pad.oe_n, p3_pad.oe_n, p8_pad.oe_n})
		else $error("high side driver on after reset");
	a_start_reset: assert property (
		!rst_n |=> !hv_slow && p2_pad.oe_n == 8'hFF)
		else $error("reset state wrong");
	a_slow_write: assert property (disable iff (!rst_n)
		bus.wr && bus.addr == `HVP_OFS_HV_CTRL
		|=> hv_slow == $past(bus.wdata[0])) else $error("slow bit not set");
	a_slow_hold: assert property (disable iff (!rst_n)
		!(bus.wr && bus.addr == `HVP_OFS_HV_CTRL) |=> $stable(hv_slow))
		else $error("slow bit changed unasked");

	c_read: cover property (bus.rd && bus.addr == `HVP_OFS_P2_DATA);
	c_dir: cover property (bus.wr && bus.addr == `HVP_OFS_P2_DIR);
	c_slow: cover property (bus.wr && bus.addr == `HVP_OFS_HV_CTRL);
endmodule // hvp_port_props

bind hvp_port_top hvp_port_props u_props (.clk, .rst_n, .bus, .rdata,
	.p2_pin, .p0_pad, .p1_pad, .p2_pad, .p3_pad, .p4_pad, .p7_pad,
	.p8_pad, .hv_slow);
`default_nettype wire

// ---- testbench/hvp_pin_load.sv ----
// outside world of one 8-bit pad group: resolves the pin level
// assumes the bench gives the level that outside loads force
`timescale 1ns/10ps
`default_nettype none
module hvp_pin_load (
	input  wire hvp_pkg::hvp_pad_t pad,
	input  wire logic [7:0]        ext,
	output logic      [7:0]        pin
);
	import hvp_pkg::*;
	// undriven bits never keep the driven value; the load decides
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin[i] = pad.oe_n[i] ? ext[i] : pad.lvl[i];
		end
	end
endmodule // hvp_pin_load
`default_nettype wire

// ---- testbench/hvp_port_top_bench.sv ----
// self-checking bench of the port block with pin loads
// assumes the register offsets of hvp_port_map.svh
`timescale 1ns/10ps
`default_nettype none
`include "hvp_port_map.svh"
module hvp_port_top_bench;
	import hvp_pkg::*;
	logic       clk;
	logic       rst_n;
	hvp_bus_t   bus;
	logic [7:0] rdata;
	logic [7:0] ext [2:8];
	logic [7:0] pin [2:8];
	hvp_pad_t   pad [0:8];
	logic       hv_slow;
	int         fails;
	int         total_checks;

	hvp_port_top DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.p2_pin(pin[2]), .p4_pin(pin[4]), .p5_pin(pin[5]),
		.p6_pin(pin[6]), .p7_pin(pin[7]), .p8_pin(pin[8]),
		.p0_pad(pad[0]), .p1_pad(pad[1]), .p2_pad(pad[2]),
		.p3_pad(pad[3]), .p4_pad(pad[4]), .p5_pad(pad[5]),
		.p6_pad(pad[6]), .p7_pad(pad[7]), .p8_pad(pad[8]),
		.hv_slow(hv_slow));

	for (genvar g = 2; g < 9; g++) begin : g_ld
		if (g != 3) begin : g_on
			hvp_pin_load u_ld (.pad(pad[g]), .ext(ext[g]), .pin(pin[g]));
		end
	end

	// ****************
	// bus and compare
	// ****************
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(negedge clk);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask

	// ****************
	// scenarios
	// ****************
	task t_reset;
		for (int i = 0; i < 9; i++) begin
			chk(pad[i].oe_n, 8'hFF);
		end
		chk({7'h00, hv_slow}, 8'h00);
		rd(`HVP_OFS_HV_CTRL, 8'h00);
		rd(`HVP_OFS_P2_DIR, 8'h00);
	endtask

	// mid-run reset with latches and slow bit set, and directions set on every port but port two
	task t_reset_again;
		wr(`HVP_OFS_HV_CTRL, 8'h01);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		t_reset;
	endtask

	task t_two_way;
		@(posedge clk);
		ext[2] <= 8'h3C;
		wr(`HVP_OFS_P2_DATA, 8'hA5);
		chk(pad[2].oe_n, 8'hFF);
		rd(`HVP_OFS_P2_DATA, 8'h3C);
		wr(`HVP_OFS_P2_DIR, 8'h0F);
		chk(pad[2].oe_n, 8'hF0);
		chk(pin[2], 8'h35);
		rd(`HVP_OFS_P2_DATA, 8'h35);
		wr(`HVP_OFS_P2_DIR, 8'h00);
		chk(pin[2], 8'h3C);
	endtask

	task t_hv;
		wr(`HVP_OFS_P0_DATA, 8'h81);
		chk(pad[0].oe_n, 8'h7E);
		wr(`HVP_OFS_P1_DATA, 8'h3C);
		chk(pad[1].oe_n, 8'hC3);
		wr(`HVP_OFS_P3_DATA, 8'hF0);
		chk(pad[3].oe_n, 8'h0F);
		wr(`HVP_OFS_P8_DATA, 8'hFF);
		chk(pad[8].oe_n, 8'hFF);
		wr(`HVP_OFS_P8_DIR, 8'h0F);
		chk(pad[8].oe_n, 8'hF0);
		wr(`HVP_OFS_HV_CTRL, 8'hFF);
		chk({7'h00, hv_slow}, 8'h01);
		rd(`HVP_OFS_HV_CTRL, 8'h01);
		wr(`HVP_OFS_HV_CTRL, 8'h00);
		chk({7'h00, hv_slow}, 8'h00);
	endtask

	task t_ports;
		logic [7:0] ofs [4] = '{8'h08, 8'h0A, 8'h0C, 8'h0E};
		logic [7:0] msk [4] = '{8'hFE, 8'hFF, 8'h3F, 8'hFF};
		logic [7:0] dat [4] = '{8'hFF, 8'hFF, 8'h3F, 8'hFF};
		// port five held low outside: output bits must still read the latch
		@(posedge clk);
		ext[5] <= 8'h00;
		for (int i = 0; i < 4; i++) begin
			wr(ofs[i], 8'hFF);
			wr(ofs[i] + 8'h01, 8'hFF);
			rd(ofs[i], dat[i]);
			rd(ofs[i] + 8'h01, msk[i]);
		end
		chk(pad[4].oe_n, 8'h01);
		chk(pad[6].oe_n, 8'hC0);
		wr(`HVP_OFS_P5_DATA, 8'h0F);
		chk(pad[5].oe_n, 8'h0F);
		chk(pad[5].lvl, 8'h00);
		rd(`HVP_OFS_P5_DATA, 8'h0F);
		rd(8'h20, 8'h00);
	endtask

	task summarize;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// run takes about 85 cycles; limit is far beyond that
	initial begin
		#100000;
		fails++;
		summarize;
	end

	initial begin
		bus = '0;
		rst_n = 1'b0;
		fails = 0;
		total_checks = 0;
		for (int i = 2; i < 9; i++) ext[i] = 8'hFF;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		t_reset;
		t_two_way;
		t_hv;
		t_ports;
		t_reset_again;
		summarize;
	end
endmodule // hvp_port_top_bench
`default_nettype wire
